// File: hdl/voice_store_map.svh
// offsets, field positions, reset values, opcodes and frame counts of the decoder
// assumes nothing; definitions only, included by bare name
`ifndef VOICE_STORE_MAP_SVH
`define VOICE_STORE_MAP_SVH
// apb register byte offsets
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_CONFIG    8'h08
`define REG_SECTOR    8'h0C
`define REG_FLAGS     8'h10
`define CTRL_RESET    1'b1
// opcodes
`define OPC_IDLE      5'h00
`define OPC_IDENT     5'h01
`define OPC_SEEK_AT   5'h02
`define OPC_SEEK_CUR  5'h03
`define OPC_POWER_ON  5'h04
`define OPC_HALT      5'h06
`define OPC_SLEEP     5'h07
`define OPC_CAP_AT    5'h08
`define OPC_CAP_CUR   5'h09
`define OPC_WIPE      5'h0A
`define OPC_LOAD      5'h0B
`define OPC_PLAY_AT   5'h0C
`define OPC_PLAY_CUR  5'h0D
`define OPC_FETCH     5'h0F
// frame bit counts (bit index of the sclk edge, counted from 0)
`define HDR_LAST      12'h013
`define LOAD_FIRST    12'h018
`define LOAD_LAST     12'h0BD3
`define LOAD_END      12'h0BD7
`define FETCH_FIRST   12'h014
`define FETCH_LAST    12'h0BCF
`define LAST_SECTOR   15'h04FF
// flag bit positions
`define FLG_MARK      0
`define FLG_OVF       1
`define FLG_ILL       2
`define FLG_PART      3
// sample rates in hz for the four rate selects
`define RATE_HZ_0     16'h1900
`define RATE_HZ_1     16'h0FA0
`define RATE_HZ_2     16'h1F40
`define RATE_HZ_3     16'h14B4
`endif

// File: hdl/voice_store_pkg.sv
// types shared by the command decoder
// assumes the map header supplies all numeric constants
package voice_store_pkg;
   // operating mode of the storage engine
   typedef enum logic [2:0] {
      MODE_IDLE     = 3'b000,
      MODE_SEEK_FIX = 3'b001,
      MODE_SEEK_RUN = 3'b010,
      MODE_CAP_FIX  = 3'b011,
      MODE_CAP_RUN  = 3'b100,
      MODE_PLAY_FIX = 3'b101,
      MODE_PLAY_RUN = 3'b110,
      MODE_SLEEP    = 3'b111
   } op_mode_e;
   // what the serial bits after the header mean
   typedef enum logic [1:0] {
      PH_CMD   = 2'b00,
      PH_LOAD  = 2'b01,
      PH_FETCH = 2'b10,
      PH_SKIP  = 2'b11
   } phase_e;
endpackage : voice_store_pkg

// File: hdl/voice_store_opcode_decoder.sv
// serial command decoder of the voice store, with an apb status/control port
// assumes spi pins asynchronous to clock_in and the sector engine on clock_in
//
// Notes on behaviour
// (R1) frame is 5-bit opcode plus 15-bit parameter
// (R2) fourteen opcodes recognised
// (R3) idle does nothing; ident selects id next frame
// (R4) seek from sector wraps within that sector
// (R5) seek from sector stops on marker, irq low
// (R6) seek continue steps sectors until marker/end
// (R7) seek continue stops on marker, irq low
// (R8) amplifiers muted during any seek
// (R9) power-on resets state, loads divider and rate
// (R10) rate select decodes to 6.4/4.0/8.0/5.3 khz
// (R11) host programs divider 1..256, never 2
// (R12) halt ends operation, any command follows
// (R13) halt_sleep powers down; only power-on follows
// (R14) capture at sector; restricted successor set
// (R15) capture continue; same restricted successors
// (R16) sector wipe erases addressed sector
// (R17) load takes address, 3004 bits, no partials
// (R18) fetch returns stored bits in order
// (R19) playback at sector; restricted successor set
// (R20) playback continue; same restricted successors
// (R21) after seek only seeks or halts follow
// (R22) bits sampled on sclk rise while cs low
// (R23) host waits for completion before next command
// (R24) unassigned opcodes behave as idle
// (R25) frames shifted opcode first, msb first
`timescale 1ns/100ps
`include "voice_store_map.svh"
`default_nettype none
module voice_store_opcode_decoder
   import voice_store_pkg::*;
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   // serial command pins
   input  wire logic        spi_sclk_in,
   input  wire logic        spi_cs_n_in,
   input  wire logic        spi_di_in,
   // sector engine events
   input  wire logic        sector_end_in,
   input  wire logic        end_marker_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // engine control
   output logic      [2:0]  op_mode_out,
   output logic      [14:0] sector_out,
   output logic             sector_restart_out,
   output logic             amp_mute_out,
   output logic             event_irq_n_out,
   output logic             ident_sel_out,
   output logic      [7:0]  clk_div_out,
   output logic      [1:0]  rate_sel_out,
   output logic             erase_pulse_out,
   // digital data streams
   output logic             load_bit_valid_out,
   output logic             load_bit_out,
   output logic             load_commit_out,
   output logic             fetch_req_out,
   output logic      [11:0] fetch_index_out
);
   // =========================================================
   // functions
   // unassigned codes fold to idle so they never change mode or sector
   function automatic logic [4:0] fold_op(input logic [4:0] op);
      unique case (op)
         `OPC_IDENT, `OPC_SEEK_AT, `OPC_SEEK_CUR, `OPC_POWER_ON, `OPC_HALT, `OPC_SLEEP,
         `OPC_CAP_AT, `OPC_CAP_CUR, `OPC_WIPE, `OPC_LOAD, `OPC_PLAY_AT,
         `OPC_PLAY_CUR, `OPC_FETCH: fold_op = op; // R2
         default:                    fold_op = `OPC_IDLE; // R24
      endcase
   endfunction : fold_op

   // which commands may follow the running operation
   function automatic logic follow_ok(input op_mode_e m, input logic [4:0] op);
      logic stop;
      stop = (op == `OPC_HALT) || (op == `OPC_SLEEP);
      unique case (m)
         MODE_SLEEP: follow_ok = (op == `OPC_POWER_ON); // R13
         MODE_CAP_FIX, MODE_CAP_RUN: follow_ok = stop || (op == `OPC_IDLE) ||
            (op == `OPC_CAP_AT) || (op == `OPC_CAP_CUR); // R14 R15
         MODE_PLAY_FIX, MODE_PLAY_RUN: follow_ok = stop || (op == `OPC_IDLE) ||
            (op == `OPC_SEEK_AT) || (op == `OPC_SEEK_CUR) ||
            (op == `OPC_PLAY_AT) || (op == `OPC_PLAY_CUR); // R19 R20
         MODE_SEEK_FIX, MODE_SEEK_RUN: follow_ok = stop ||
            (op == `OPC_SEEK_AT) || (op == `OPC_SEEK_CUR); // R21
         MODE_IDLE: follow_ok = 1'b1; // R3 R12
      endcase
   endfunction : follow_ok

   // sample rate in hz for a rate select
   function automatic logic [15:0] rate_hz(input logic [1:0] sel);
      unique case (sel)
         2'b00: rate_hz = `RATE_HZ_0; // R10
         2'b01: rate_hz = `RATE_HZ_1;
         2'b10: rate_hz = `RATE_HZ_2;
         2'b11: rate_hz = `RATE_HZ_3;
      endcase
   endfunction : rate_hz

   // =========================================================
   // pin synchronisers: bit 2 sclk, bit 1 cs_n, bit 0 data
   logic [2:0] pins;       // raw pins
   logic [2:0] s1_reg;     // first stage, read only by s2
   logic [2:0] s2_reg;     // second stage
   logic [2:0] s3_reg;     // third stage
   logic [2:0] pin_reg;    // accepted level
   logic [2:0] prev_reg;   // accepted level one cycle ago
   assign pins = {spi_sclk_in, spi_cs_n_in, spi_di_in};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         // a change counts only once stages two and three agree
         always_ff @(posedge clock_in) begin
            if (sys_rst_in) begin
               s1_reg[gi]  <= (gi == 1);
               s2_reg[gi]  <= (gi == 1);
               s3_reg[gi]  <= (gi == 1);
               pin_reg[gi] <= (gi == 1);
            end else begin
               s1_reg[gi] <= pins[gi];
               s2_reg[gi] <= s1_reg[gi];
               s3_reg[gi] <= s2_reg[gi];
               if (s2_reg[gi] == s3_reg[gi]) begin
                  pin_reg[gi] <= s3_reg[gi];
               end
            end
         end
      end
   endgenerate

   // previous accepted level for edge detection
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         prev_reg <= 3'h2;
      end else begin
         prev_reg <= pin_reg;
      end
   end

   logic sclk_rise;  // sampling edge inside a frame
   logic cs_rise;    // frame ends
   assign sclk_rise = pin_reg[2] & ~prev_reg[2] & ~pin_reg[1]; // R22
   assign cs_rise   = pin_reg[1] & ~prev_reg[1];

   // =========================================================
   // frame shifter and bit counter
   logic [11:0] cnt_reg;    // index of next bit in the frame
   logic [18:0] shift_reg;  // header bits so far
   logic        hdr_done;   // twentieth header bit arrives now
   logic [19:0] frame;      // complete header
   logic [4:0]  opc;        // folded opcode
   logic [14:0] param;      // parameter field
   assign hdr_done = sclk_rise && (cnt_reg == `HDR_LAST); // R1
   assign frame    = {shift_reg, pin_reg[0]};
   assign opc      = fold_op(frame[19:15]); // R25
   assign param    = frame[14:0];

   // counter saturates so long streams never wrap into a new header
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || pin_reg[1]) begin
         cnt_reg <= 12'h000;
      end else if (sclk_rise && cnt_reg != `LOAD_END) begin
         cnt_reg <= cnt_reg + 12'h001;
      end
   end

   // header bits enter msb first
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         shift_reg <= 19'h00000;
      end else if (sclk_rise && cnt_reg < `HDR_LAST) begin
         shift_reg <= {shift_reg[17:0], pin_reg[0]}; // R22 R25
      end
   end

   // =========================================================
   // command acceptance
   logic     ctrl_en_reg;  // software enable of command decoding
   op_mode_e mode_reg;     // running operation
   logic     cmd_ok;       // accepted command this cycle
   logic     cmd_bad;      // refused successor this cycle
   assign cmd_ok  = hdr_done && ctrl_en_reg && follow_ok(mode_reg, opc);
   assign cmd_bad = hdr_done && ctrl_en_reg && !follow_ok(mode_reg, opc);

   // phase of the bits after the header
   phase_e phase_reg;
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || pin_reg[1]) begin
         phase_reg <= PH_CMD;
      end else if (hdr_done) begin
         if (cmd_ok && opc == `OPC_LOAD) begin
            phase_reg <= PH_LOAD; // R17
         end else if (cmd_ok && opc == `OPC_FETCH) begin
            phase_reg <= PH_FETCH; // R18
         end else begin
            phase_reg <= PH_SKIP;
         end
      end else if (sclk_rise && phase_reg == PH_LOAD && cnt_reg == `LOAD_END) begin
         phase_reg <= PH_SKIP;
      end else if (sclk_rise && phase_reg == PH_FETCH && cnt_reg == `FETCH_LAST) begin
         phase_reg <= PH_SKIP;
      end
   end

   // =========================================================
   // mode and sector sequencing
   op_mode_e    mode_next;
   logic [14:0] sector_reg;
   logic [14:0] sector_next;
   logic        restart_next;
   logic        stop_eod;    // stopped on an end marker
   logic        stop_seek;   // that stop ends a seek
   logic        stop_ovf;    // capture ran off the array
   logic        seeking;
   assign seeking = (mode_reg == MODE_SEEK_FIX) || (mode_reg == MODE_SEEK_RUN);

   // a command in the same cycle as an engine event wins
   always_comb begin
      mode_next    = mode_reg;
      sector_next  = sector_reg;
      restart_next = 1'b0;
      stop_eod     = 1'b0;
      stop_seek    = 1'b0;
      stop_ovf     = 1'b0;
      if (cmd_ok) begin
         unique case (opc)
            `OPC_SEEK_AT: begin
               mode_next    = MODE_SEEK_FIX; // R4
               sector_next  = param;
               restart_next = 1'b1;
            end
            `OPC_SEEK_CUR: begin
               mode_next    = MODE_SEEK_RUN; // R6
               restart_next = 1'b1;
            end
            `OPC_POWER_ON: begin
               mode_next   = MODE_IDLE; // R9
               sector_next = 15'h0000;
            end
            `OPC_HALT: mode_next = MODE_IDLE; // R12
            `OPC_SLEEP: mode_next = MODE_SLEEP; // R13
            `OPC_CAP_AT: begin
               mode_next    = MODE_CAP_FIX; // R14
               sector_next  = param;
               restart_next = 1'b1;
            end
            `OPC_CAP_CUR: begin
               mode_next    = MODE_CAP_RUN; // R15
               restart_next = 1'b1;
            end
            `OPC_PLAY_AT: begin
               mode_next    = MODE_PLAY_FIX; // R19
               sector_next  = param;
               restart_next = 1'b1;
            end
            `OPC_PLAY_CUR: begin
               mode_next    = MODE_PLAY_RUN; // R20
               restart_next = 1'b1;
            end
            `OPC_WIPE, `OPC_LOAD, `OPC_FETCH: begin
               mode_next   = MODE_IDLE; // R16 R17 R18
               sector_next = param;
            end
            default: mode_next = mode_reg; // R3 R24
         endcase
      end else if (end_marker_in && (seeking || mode_reg == MODE_PLAY_FIX ||
                                     mode_reg == MODE_PLAY_RUN)) begin
         mode_next = MODE_IDLE; // R5 R7
         stop_eod  = 1'b1;
         stop_seek = seeking;
      end else if (sector_end_in) begin
         unique case (mode_reg)
            MODE_SEEK_FIX, MODE_CAP_FIX, MODE_PLAY_FIX: restart_next = 1'b1; // R4
            MODE_SEEK_RUN, MODE_CAP_RUN, MODE_PLAY_RUN: begin
               if (sector_reg == `LAST_SECTOR) begin
                  mode_next = MODE_IDLE; // R6
                  stop_ovf  = (mode_reg == MODE_CAP_RUN);
               end else begin
                  sector_next  = sector_reg + 15'h0001; // R6
                  restart_next = 1'b1;
               end
            end
            default: restart_next = 1'b0;
         endcase
      end
   end

   // engine state and its outputs; device powers up asleep
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         mode_reg           <= MODE_SLEEP;
         sector_reg         <= 15'h0000;
         sector_restart_out <= 1'b0;
         amp_mute_out       <= 1'b0;
      end else begin
         mode_reg           <= mode_next;
         sector_reg         <= sector_next;
         sector_restart_out <= restart_next;
         amp_mute_out       <= (mode_next == MODE_SEEK_FIX) ||
                               (mode_next == MODE_SEEK_RUN); // R8
      end
   end
   assign op_mode_out = mode_reg;
   assign sector_out  = sector_reg;

   // =========================================================
   // configuration, ident select and erase strobe
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         clk_div_out     <= 8'h00;
         rate_sel_out    <= 2'b00;
         ident_sel_out   <= 1'b0;
         erase_pulse_out <= 1'b0;
      end else begin
         if (cmd_ok && opc == `OPC_POWER_ON) begin
            clk_div_out  <= param[9:2]; // R9 R11
            rate_sel_out <= param[1:0]; // R10
         end
         if (hdr_done) begin
            ident_sel_out <= cmd_ok && (opc == `OPC_IDENT); // R3
         end
         erase_pulse_out <= cmd_ok && (opc == `OPC_WIPE); // R16
      end
   end

   // =========================================================
   // digital data streams
   logic load_slot;   // a data bit of a load frame
   logic fetch_slot;  // a bit slot of a fetch frame
   assign load_slot  = sclk_rise && phase_reg == PH_LOAD &&
                       cnt_reg >= `LOAD_FIRST && cnt_reg <= `LOAD_LAST;
   assign fetch_slot = sclk_rise && phase_reg == PH_FETCH &&
                       cnt_reg >= `FETCH_FIRST && cnt_reg <= `FETCH_LAST;

   // commit only after the last don't-care bit, so a short frame never lands
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         load_bit_valid_out <= 1'b0;
         load_bit_out       <= 1'b0;
         load_commit_out    <= 1'b0;
         fetch_req_out      <= 1'b0;
         fetch_index_out    <= 12'h000;
      end else begin
         load_bit_valid_out <= load_slot; // R17
         load_bit_out       <= load_slot ? pin_reg[0] : load_bit_out;
         load_commit_out    <= sclk_rise && phase_reg == PH_LOAD &&
                               cnt_reg == `LOAD_END; // R17
         fetch_req_out      <= fetch_slot; // R18
         if (fetch_slot) begin
            fetch_index_out <= cnt_reg - `FETCH_FIRST; // R18
         end
      end
   end

   // =========================================================
   // sticky flags and interrupt; a set in the clearing cycle wins
   logic [3:0] flag_reg;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic       apb_wr;
   assign apb_wr   = psel_in && penable_in && pwrite_in && pready_out;
   assign flag_set = {cs_rise && phase_reg == PH_LOAD, cmd_bad, stop_ovf, stop_eod};
   assign flag_clr = (apb_wr && paddr_in == `REG_FLAGS) ? pwdata_in[3:0] : 4'h0;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         flag_reg <= 4'h0;
      end else begin
         flag_reg <= (flag_reg & ~flag_clr) | flag_set; // R17
      end
   end

   // irq released by the next accepted command or by clearing the flag
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         event_irq_n_out <= 1'b1;
      end else if (stop_seek) begin
         event_irq_n_out <= 1'b0; // R5 R7
      end else if (cmd_ok || flag_clr[`FLG_MARK]) begin
         event_irq_n_out <= 1'b1;
      end
   end

   // =========================================================
   // apb slave: one wait state, error on unmapped offsets
   logic        mapped;
   logic [31:0] rd_data;
   always_comb begin
      mapped  = 1'b1;
      rd_data = 32'h00000000;
      unique case (paddr_in)
         `REG_CTRL:   rd_data = {31'h00000000, ctrl_en_reg};
         `REG_STATUS: rd_data = {27'h0000000, ident_sel_out, ~event_irq_n_out, mode_reg};
         `REG_CONFIG: rd_data = {rate_hz(rate_sel_out), 6'h00, clk_div_out, rate_sel_out};
         `REG_SECTOR: rd_data = {17'h00000, sector_reg};
         `REG_FLAGS:  rd_data = {28'h0000000, flag_reg};
         default:     mapped  = 1'b0;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h00000000;
      end else if (psel_in && penable_in && !pready_out) begin
         pready_out  <= 1'b1;
         pslverr_out <= !mapped;
         prdata_out  <= (pwrite_in || !mapped) ? 32'h00000000 : rd_data;
      end else begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end

   // software enable of the decoder
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ctrl_en_reg <= `CTRL_RESET;
      end else if (apb_wr && paddr_in == `REG_CTRL) begin
         ctrl_en_reg <= pwdata_in[0];
      end
   end

   // =========================================================
   // assertions
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   sequence seek_hits_marker;
      seeking && end_marker_in && !hdr_done;
   endsequence
   sequence run_steps;
      !hdr_done && !end_marker_in && sector_end_in && sector_reg != `LAST_SECTOR;
   endsequence

   frame_length_a : assert property (hdr_done |=> cnt_reg == 12'h014) // R1
      else $error("header decoded off the twentieth bit");
   msb_first_a : assert property (sclk_rise && cnt_reg == 12'h000 // R25
                                  |=> shift_reg[0] == $past(pin_reg[0]))
      else $error("first frame bit not at the bottom of the shifter");
   cs_gate_a : assert property ($changed(shift_reg) |-> !$past(pin_reg[1])) // R22
      else $error("bits shifted while cs high");
   seek_irq_a : assert property (seek_hits_marker |=> !event_irq_n_out
                                 && mode_reg == MODE_IDLE) // R5
      else $error("marker in seek did not stop and interrupt");
   seek_mute_a : assert property (seeking |-> amp_mute_out) // R8
      else $error("outputs not muted during seek");
   fix_wrap_a : assert property (mode_reg == MODE_SEEK_FIX ##0 run_steps
                                 |=> sector_reg == $past(sector_reg) && sector_restart_out) // R4
      else $error("seek from sector did not wrap");
   seek_step_a : assert property (mode_reg == MODE_SEEK_RUN ##0 run_steps
                                  |=> sector_reg == $past(sector_reg) + 15'h0001) // R6
      else $error("seek continue did not advance");
   sleep_guard_a : assert property (mode_reg == MODE_SLEEP && hdr_done
                                    && opc != `OPC_POWER_ON |=> mode_reg == MODE_SLEEP) // R13
      else $error("sleep left without power-on");
   capture_follow_a : assert property (mode_reg == MODE_CAP_RUN && hdr_done // R15
                                       && ctrl_en_reg && !sector_end_in && opc == `OPC_SEEK_AT
                                       |=> flag_reg[`FLG_ILL]
                                       && mode_reg == MODE_CAP_RUN)
      else $error("illegal successor of capture taken");
   unknown_idle_a : assert property (hdr_done && frame[19:15] == 5'h05 // R24
                                     && !end_marker_in && !sector_end_in
                                     |=> mode_reg == $past(mode_reg))
      else $error("unassigned opcode changed state");
   load_full_a : assert property (load_commit_out |-> $past(cnt_reg) == 12'h0BD7) // R17
      else $error("load committed before all bits");
   fetch_order_a : assert property (fetch_req_out |-> fetch_index_out
                                    == $past(cnt_reg) - 12'h014) // R18
      else $error("fetch index out of order");
endmodule : voice_store_opcode_decoder
`default_nettype wire

// File: verification/spi_host_model.sv
// host side of the serial command pins: shifts whole 20-bit frames
// assumes clock_in is the design clock; sclk halves last 5 clocks, above the 2 needed
`timescale 1ns/100ps
`default_nettype none
// ====
// frame sender
module spi_host_model (
   // clock
   input  wire logic clock_in,
   // serial pins
   output var  logic sclk_out,
   output var  logic cs_n_out,
   output var  logic di_out
);
   // sclk stands low outside frames, select idles high
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      di_out   = 1'b0;
   end
   // send one frame, opcode first and msb first, data set up before each rise
   task automatic send(input logic [19:0] frame);
      @(posedge clock_in);
      cs_n_out <= 1'b0;
      for (int i = 19; i >= 0; i--) begin
         di_out <= frame[i];
         repeat (5) @(posedge clock_in);
         sclk_out <= 1'b1;
         repeat (5) @(posedge clock_in);
         sclk_out <= 1'b0;
      end
      repeat (5) @(posedge clock_in);
      cs_n_out <= 1'b1;
      // released data line shows the inverse, never a stale bit
      di_out   <= ~di_out;
      // gap lets the decode land before the next look
      repeat (10) @(posedge clock_in);
   endtask : send
endmodule : spi_host_model
`default_nettype wire

// File: verification/test_voice_store_opcode_decoder.sv
// self-checking bench: command frames through the host model, results via apb and the dut output ports
// assumes the package, map header and design are compiled first
`timescale 1ns/100ps
`include "voice_store_map.svh"
`default_nettype none
// ====
// bench top
module test_voice_store_opcode_decoder;
   import voice_store_pkg::*;
   logic        clock_in = 1'b0, sys_rst_in = 1'b1, end_marker_in = 1'b0, psel_in = 1'b0;
   logic        penable_in = 1'b0, pwrite_in = 1'b0, sclk, cs_n, di, err, pready_out;
   logic        pslverr_out, amp_mute_out, event_irq_n_out, sector_end_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00, clk_div_out;
   logic [31:0] pwdata_in = 32'h0, rd, prdata_out;
   logic [2:0]  op_mode_out;
   logic [14:0] sector_out;
   logic [1:0]  rate_sel_out;
   int          n_fail = 0, num_checks = 0;
   // 25 mhz clock
   always #20 clock_in = ~clock_in;
   spi_host_model u_host (.clock_in(clock_in), .sclk_out(sclk), .cs_n_out(cs_n), .di_out(di));
   voice_store_opcode_decoder u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_di_in(di), .sector_end_in(sector_end_in),
      .end_marker_in(end_marker_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .op_mode_out(op_mode_out), .sector_out(sector_out), .sector_restart_out(),
      .amp_mute_out(amp_mute_out), .event_irq_n_out(event_irq_n_out), .ident_sel_out(),
      .clk_div_out(clk_div_out), .rate_sel_out(rate_sel_out), .erase_pulse_out(),
      .load_bit_valid_out(), .load_bit_out(), .load_commit_out(), .fetch_req_out(),
      .fetch_index_out());
   // verdict and end of run
   task automatic conclude();
      if (n_fail == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clock_in);
      psel_in   <= 1'b1;
      pwrite_in <= w;
      paddr_in  <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      r = prdata_out;
      e = pslverr_out;
      if (pready_out !== 1'b1) begin
         n_fail++;
         conclude();
      end
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   // send a command frame
   task automatic cmd(input logic [4:0] op, input logic [14:0] p);
      u_host.send({op, p});
   endtask : cmd
   // one-cycle engine event: marker when m is high, sector end otherwise
   task automatic pulse(input logic m);
      @(posedge clock_in);
      if (m) end_marker_in <= 1'b1;
      else sector_end_in <= 1'b1;
      @(posedge clock_in);
      end_marker_in <= 1'b0;
      sector_end_in <= 1'b0;
      repeat (2) @(posedge clock_in);
   endtask : pulse
   // hang guard
   initial begin
      repeat (20000) @(posedge clock_in);
      n_fail++;
      conclude();
   end
   // ====
   // main sequence
   initial begin
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      chk({op_mode_out, event_irq_n_out}, 32'hF);
      cmd(`OPC_POWER_ON, 15'h0022);
      chk({op_mode_out, clk_div_out, rate_sel_out}, 32'h22);
      apb(1'b0, `REG_CONFIG, 32'h0, rd, err);
      chk(rd, {16'h1F40, 6'h00, 8'h08, 2'h2});
      cmd(`OPC_SEEK_AT, 15'h0005);
      chk({op_mode_out, sector_out, amp_mute_out}, {13'h0, 3'h1, 15'h0005, 1'b1});
      pulse(1'b0);
      chk({op_mode_out, sector_out}, {3'h1, 15'h0005});
      pulse(1'b1);
      chk({op_mode_out, amp_mute_out, event_irq_n_out}, 32'h0);
      cmd(`OPC_SEEK_CUR, 15'h0);
      pulse(1'b0);
      chk({op_mode_out, sector_out, amp_mute_out}, {3'h2, 15'h0006, 1'b1});
      pulse(1'b1);
      chk({op_mode_out, amp_mute_out, event_irq_n_out}, 32'h0);
      cmd(`OPC_HALT, 15'h0);
      chk({op_mode_out, event_irq_n_out}, 32'h1);
      cmd(`OPC_IDENT, 15'h0);
      apb(1'b0, `REG_STATUS, 32'h0, rd, err);
      chk(rd, 32'h10);
      cmd(`OPC_WIPE, 15'h0009);
      chk({op_mode_out, sector_out}, 32'h9);
      cmd(5'h05, 15'h7FFF);
      chk({op_mode_out, sector_out}, 32'h9);
      cmd(`OPC_SLEEP, 15'h0);
      cmd(`OPC_CAP_AT, 15'h0003);
      chk(op_mode_out, 32'h7);
      apb(1'b0, `REG_FLAGS, 32'h0, rd, err);
      chk(rd, 32'h5);
      apb(1'b1, `REG_FLAGS, 32'h5, rd, err);
      apb(1'b0, `REG_FLAGS, 32'h0, rd, err);
      chk(rd, 32'h0);
      apb(1'b0, 8'h14, 32'h0, rd, err);
      chk({err, rd[30:0]}, 32'h80000000);
      conclude();
   end
endmodule : test_voice_store_opcode_decoder
`default_nettype wire
